/* File: verilog/mmdia_mmd_access.sv */
// How it works
// RULE1 - manager loads pointer with function address first
// RULE2 - manager picks increment mode by control value
// RULE3 - post-increment writes store then advance pointer
// RULE4 - read-write increment mode reads then advances pointer
// RULE5 - manager bursts reads after selecting read increment
// RULE6 - data mode without increment keeps pointer fixed
// RULE7 - control at 0x0D, address/data at 0x0E
// RULE8 - clock config register resets to 0x0C10
// RULE9 - writing 0x0C50 there stops clock output
// RULE10 - write-only increment mode: reads keep pointer
// RULE11 - wrong device address accesses are ignored
// RULE12 - function in 15:14, device address 4:0
// RULE13 - indirect access to 0x0D/0x0E is ignored
// RULE14 - sixteen bit pointer wraps to zero
module mmdia_mmd_access (
	input  wire logic ref_clk,    // core clock
	input  wire logic resetn,     // synchronous reset, active low
	input  wire logic mdc,        // management clock from the station
	input  wire logic mdio_in,    // serial data pin, input side
	output logic      mdio_out,   // serial data pin, output side
	output logic      mdio_oe,    // high while driving the pin
	output logic      clk_out_oe  // high while the clock output pin is driven
);
	mmdia_pkg::mmdia_req_t rec;
	logic                  req_tog;
	logic                  req_s1, req_s2, req_s3;
	logic                  req_evt;
	logic [15:0]           ctrl_reg, ctrl_next;
	logic [15:0]           ptr_reg, ptr_next;
	// packed so that whole-window stability can be asserted in one term
	logic [mmdia_pkg::EXT_DEPTH-1:0][15:0] mem_reg;
	logic [mmdia_pkg::EXT_DEPTH-1:0][15:0] mem_next;
	logic [15:0]           pub_ctrl_reg, pub_ctrl_next;
	logic [15:0]           pub_ad_reg, pub_ad_next;
	logic                  ack_reg, ack_next;
	logic                  clk_out_oe_reg, clk_out_oe_next;
	logic [1:0]            func;
	logic                  dev_addr_ok;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic ext_hit(input logic [15:0] addr);
		return addr[15:mmdia_pkg::EXT_IDX_W] == mmdia_pkg::EXT_BASE[15:mmdia_pkg::EXT_IDX_W];
	endfunction

	function automatic logic ind_blocked(input logic [15:0] addr);
		return (addr == mmdia_pkg::DIRECT_CTRL_PTR) || (addr == mmdia_pkg::DIRECT_AD_PTR);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	mmdia_link u_link (
		.mdc           (mdc),
		.resetn        (resetn),
		.mdio_in       (mdio_in),
		.mdio_out      (mdio_out),
		.mdio_oe       (mdio_oe),
		.pub_ctrl      (pub_ctrl_reg),
		.pub_addr_data (pub_ad_reg),
		.ack_tog       (ack_reg),
		.req_tog       (req_tog),
		.req_rec       (rec)
	);

	// the record is held by the link until acknowledged, so it is stable here
	always_ff @(posedge ref_clk) begin
		req_s1 <= req_tog;
		req_s2 <= req_s1;
		req_s3 <= req_s2;
	end

	assign req_evt  = req_s2 ^ req_s3;
	// RULE12 field decode
	assign func     = ctrl_reg[mmdia_pkg::FUNC_MSB:mmdia_pkg::FUNC_LSB];
	assign dev_addr_ok = ctrl_reg[mmdia_pkg::TARGET_DEV_MSB:mmdia_pkg::TARGET_DEV_LSB]
		== mmdia_pkg::TARGET_DEV_ALL;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		ctrl_next = ctrl_reg;
		ptr_next  = ptr_reg;
		mem_next  = mem_reg;
		ack_next  = ack_reg;
		if (req_evt) begin
			ack_next = req_s2;
			// RULE7 direct control write
			if (rec.wr && rec.reg_addr == mmdia_pkg::ADDR_ACCESS_CTRL) begin
				ctrl_next = rec.data;
			// RULE11 device address gate
			end else if (rec.reg_addr == mmdia_pkg::ADDR_ADDR_DATA && dev_addr_ok) begin
				if (func == mmdia_pkg::FN_ADDRESS) begin
					// RULE12 pointer access mode
					if (rec.wr)
						ptr_next = rec.data;
				// RULE13 block self access
				end else if (!ind_blocked(ptr_reg)) begin
					// RULE6 addressed data write
					if (rec.wr && ext_hit(ptr_reg))
						mem_next[ptr_reg[mmdia_pkg::EXT_IDX_W-1:0]] = rec.data;
					// RULE3 RULE4 RULE10 RULE14 advance pointer
					if (func == mmdia_pkg::FN_INC_RW || (func == mmdia_pkg::FN_INC_WR && rec.wr))
						ptr_next = ptr_reg + mmdia_pkg::PTR_STEP;
				end
			end
		end
	end

	// read views are rebuilt from the next state so they settle with the ack toggle
	always_comb begin
		pub_ctrl_next = ctrl_next;
		if (ctrl_next[mmdia_pkg::TARGET_DEV_MSB:mmdia_pkg::TARGET_DEV_LSB]
			!= mmdia_pkg::TARGET_DEV_ALL)
			pub_ad_next = mmdia_pkg::UNMAPPED_DATA;
		else if (ctrl_next[mmdia_pkg::FUNC_MSB:mmdia_pkg::FUNC_LSB] == mmdia_pkg::FN_ADDRESS)
			pub_ad_next = ptr_next;
		else if (ind_blocked(ptr_next) || !ext_hit(ptr_next))
			pub_ad_next = mmdia_pkg::UNMAPPED_DATA;
		else
			pub_ad_next = mem_next[ptr_next[mmdia_pkg::EXT_IDX_W-1:0]];
		// RULE9 clock output disable
		clk_out_oe_next = !mem_next[mmdia_pkg::CLKCFG_IDX][mmdia_pkg::CLKOUT_DIS_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_reg       <= mmdia_pkg::CTRL_RESET;
			ptr_reg        <= mmdia_pkg::PTR_RESET;
			ack_reg        <= 1'b0;
			pub_ctrl_reg   <= mmdia_pkg::CTRL_RESET;
			pub_ad_reg     <= mmdia_pkg::UNMAPPED_DATA;
			clk_out_oe_reg <= !mmdia_pkg::EXT_CLKCFG_RESET[mmdia_pkg::CLKOUT_DIS_BIT];
			// RULE8 clock config reset
			for (int i = 0; i < mmdia_pkg::EXT_DEPTH; i++) begin
				mem_reg[i] <= (i == int'(mmdia_pkg::CLKCFG_IDX))
					? mmdia_pkg::EXT_CLKCFG_RESET : mmdia_pkg::EXT_RESET;
			end
		end else begin
			ctrl_reg       <= ctrl_next;
			ptr_reg        <= ptr_next;
			ack_reg        <= ack_next;
			pub_ctrl_reg   <= pub_ctrl_next;
			pub_ad_reg     <= pub_ad_next;
			clk_out_oe_reg <= clk_out_oe_next;
			mem_reg        <= mem_next;
		end
	end

	assign clk_out_oe = clk_out_oe_reg;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_ad_access;
		req_evt && rec.reg_addr == mmdia_pkg::ADDR_ADDR_DATA && dev_addr_ok;
	endsequence

	sequence s_data_access;
		s_ad_access ##0 (func != mmdia_pkg::FN_ADDRESS) && !ind_blocked(ptr_reg);
	endsequence

	property p_ctrl_write;
		req_evt && rec.wr && rec.reg_addr == mmdia_pkg::ADDR_ACCESS_CTRL
		|=> ctrl_reg == $past(rec.data) ##1 pub_ctrl_reg == ctrl_reg;
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // RULE7

	property p_ptr_load;
		s_ad_access ##0 rec.wr && func == mmdia_pkg::FN_ADDRESS
		|=> ptr_reg == $past(rec.data) && pub_ad_reg == ptr_reg;
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong"); // RULE12

	property p_wr_inc;
		s_data_access ##0 rec.wr && func[1]
		|=> ptr_reg == $past(ptr_reg) + mmdia_pkg::PTR_STEP;
	endproperty
	a_wr_inc: assert property (p_wr_inc) else $error("no advance after write"); // RULE3

	property p_rd_inc;
		s_data_access ##0 !rec.wr && func == mmdia_pkg::FN_INC_RW
		|=> ptr_reg == $past(ptr_reg) + mmdia_pkg::PTR_STEP;
	endproperty
	a_rd_inc: assert property (p_rd_inc) else $error("no advance after read"); // RULE4

	property p_rd_hold;
		s_data_access ##0 !rec.wr && func == mmdia_pkg::FN_INC_WR |=> $stable(ptr_reg);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read moved pointer"); // RULE10

	property p_no_inc;
		s_data_access ##0 func == mmdia_pkg::FN_DATA |=> $stable(ptr_reg);
	endproperty
	a_no_inc: assert property (p_no_inc) else $error("pointer moved without increment"); // RULE6

	property p_dev_addr;
		req_evt && rec.reg_addr == mmdia_pkg::ADDR_ADDR_DATA && !dev_addr_ok
		|=> $stable(ptr_reg) && $stable(mem_reg);
	endproperty
	a_dev_addr: assert property (p_dev_addr) else $error("foreign device address acted on"); // RULE11

	property p_self_block;
		s_ad_access ##0 func != mmdia_pkg::FN_ADDRESS && ind_blocked(ptr_reg)
		|=> $stable(ptr_reg) && $stable(mem_reg);
	endproperty
	a_self_block: assert property (p_self_block) else $error("indirect self access acted"); // RULE13

	property p_clkcfg_reset;
		$rose(resetn) |-> mem_reg[mmdia_pkg::CLKCFG_IDX] == mmdia_pkg::EXT_CLKCFG_RESET && clk_out_oe_reg;
	endproperty
	a_clkcfg_reset: assert property (p_clkcfg_reset) else $error("clock config reset wrong"); // RULE8

	property p_clk_stop;
		s_data_access ##0 rec.wr && rec.data == 16'h0C50
			&& ptr_reg == mmdia_pkg::EXT_BASE
		|=> !clk_out_oe_reg [*2];
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock output not stopped"); // RULE9

	property p_ack;
		req_evt |=> ack_reg == req_s3 ##1 !req_evt;
	endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged"); // RULE7

	// the pointer must roll over, never stick at the top
	property p_ptr_wrap;
		s_data_access ##0 func[1] && (rec.wr || !func[0]) && ptr_reg == 16'hFFFF
		|=> ptr_reg == 16'h0000;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap"); // RULE14

	property p_ext_write;
		s_data_access ##0 rec.wr && ext_hit(ptr_reg)
		|=> mem_reg[$past(ptr_reg[mmdia_pkg::EXT_IDX_W-1:0])] == $past(rec.data);
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("extended write lost"); // RULE6
endmodule // mmdia_mmd_access

/* File: verilog/mmdia_pkg.sv */
package mmdia_pkg;
	// direct management register addresses
	localparam logic [4:0]  ADDR_ACCESS_CTRL = 5'h0D;
	localparam logic [4:0]  ADDR_ADDR_DATA   = 5'h0E;
	// station address this device answers on
	localparam logic [4:0]  PHY_ADDRESS      = 5'h01;
	localparam logic [4:0]  TARGET_DEV_ALL   = 5'h1F;
	// access control fields
	localparam int          FUNC_MSB         = 15;
	localparam int          FUNC_LSB         = 14;
	localparam int          TARGET_DEV_MSB   = 4;
	localparam int          TARGET_DEV_LSB   = 0;
	localparam logic [1:0]  FN_ADDRESS       = 2'h0;
	localparam logic [1:0]  FN_DATA          = 2'h1;
	localparam logic [1:0]  FN_INC_RW        = 2'h2;
	localparam logic [1:0]  FN_INC_WR        = 2'h3;
	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam logic [15:0] PTR_RESET        = 16'h0000;
	localparam logic [15:0] PTR_STEP         = 16'h0001;
	// extended register window
	localparam logic [15:0] EXT_BASE         = 16'h0170;
	localparam int          EXT_IDX_W        = 4;
	localparam int          EXT_DEPTH        = 16;
	localparam logic [3:0]  CLKCFG_IDX       = 4'h0;
	localparam logic [15:0] EXT_CLKCFG_RESET = 16'h0C10;
	localparam logic [15:0] EXT_RESET        = 16'h0000;
	localparam int          CLKOUT_DIS_BIT   = 6;
	localparam logic [15:0] DIRECT_CTRL_PTR  = 16'h000D;
	localparam logic [15:0] DIRECT_AD_PTR    = 16'h000E;
	localparam logic [15:0] UNMAPPED_DATA    = 16'h0000;
	localparam logic [15:0] READ_FAIL        = 16'hFFFF;
	// serial frame
	localparam logic [1:0]  OP_WRITE         = 2'h1;
	localparam logic [1:0]  OP_READ          = 2'h2;
	localparam logic [4:0]  HDR_LAST         = 5'h0C;
	localparam logic [4:0]  TA_LAST          = 5'h01;
	localparam logic [4:0]  DATA_LAST        = 5'h0F;

	typedef struct packed {
		logic        wr;
		logic [4:0]  reg_addr;
		logic [15:0] data;
	} mmdia_req_t;

	localparam mmdia_req_t REQ_RESET = '0;

	typedef enum logic [1:0] {LS_IDLE, LS_HDR, LS_TA, LS_DATA} mmdia_link_state_t;
endpackage

/* File: verilog/mmdia_link.sv */
module mmdia_link (
	input  wire logic                  mdc,           // management clock
	input  wire logic                  resetn,        // raw reset, resynchronised here
	input  wire logic                  mdio_in,       // serial data pin, input side
	output logic                       mdio_out,      // serial data pin, output side
	output logic                       mdio_oe,       // high while driving the pin
	input  wire logic [15:0]           pub_ctrl,      // read view of access control
	input  wire logic [15:0]           pub_addr_data, // read view of address/data
	input  wire logic                  ack_tog,       // core done toggle
	output logic                       req_tog,       // new request toggle
	output mmdia_pkg::mmdia_req_t      req_rec        // held request record
);
	mmdia_pkg::mmdia_link_state_t state_reg, state_next;
	mmdia_pkg::mmdia_req_t        rec_reg, rec_next;
	logic [4:0]                   cnt_reg, cnt_next, reg_addr_reg, reg_addr_next;
	logic [15:0]                  in_sh_reg, in_sh_next, out_sh_reg, out_sh_next;
	logic                         rd_reg, rd_next, wr_reg, wr_next;
	logic                         tog_reg, tog_next, out_reg, out_next, oe_reg, oe_next;
	logic                         rst_s1, rst_s2, ack_s1, ack_s2;
	logic [12:0]                  hdr;
	logic                         idle_ok;

	always_ff @(posedge mdc) begin
		rst_s1 <= resetn;
		rst_s2 <= rst_s1;
		ack_s1 <= ack_tog;
		ack_s2 <= ack_s1;
	end

	assign hdr     = {in_sh_reg[11:0], mdio_in};
	// core words are only sampled once the previous request is acknowledged
	assign idle_ok = (ack_s2 == tog_reg);

	always_comb begin
		state_next    = state_reg;
		rec_next      = rec_reg;
		cnt_next      = cnt_reg;
		reg_addr_next = reg_addr_reg;
		in_sh_next    = in_sh_reg;
		out_sh_next   = out_sh_reg;
		rd_next       = rd_reg;
		wr_next       = wr_reg;
		tog_next      = tog_reg;
		out_next      = out_reg;
		oe_next       = oe_reg;
		case (state_reg)
			mmdia_pkg::LS_IDLE: begin
				if (!mdio_in) begin
					state_next = mmdia_pkg::LS_HDR;
					cnt_next   = '0;
				end
			end
			mmdia_pkg::LS_HDR: begin
				in_sh_next = {in_sh_reg[14:0], mdio_in};
				cnt_next   = cnt_reg + 5'h01;
				if (cnt_reg == mmdia_pkg::HDR_LAST) begin
					state_next    = mmdia_pkg::LS_TA;
					cnt_next      = '0;
					reg_addr_next = hdr[4:0];
					rd_next = hdr[12] && (hdr[11:10] == mmdia_pkg::OP_READ)
						&& (hdr[9:5] == mmdia_pkg::PHY_ADDRESS);
					wr_next = hdr[12] && (hdr[11:10] == mmdia_pkg::OP_WRITE)
						&& (hdr[9:5] == mmdia_pkg::PHY_ADDRESS);
					out_sh_next = mmdia_pkg::READ_FAIL;
					// RULE7 direct register decode
					if (rd_next && idle_ok) begin
						if (hdr[4:0] == mmdia_pkg::ADDR_ACCESS_CTRL)
							out_sh_next = pub_ctrl;
						else if (hdr[4:0] == mmdia_pkg::ADDR_ADDR_DATA)
							out_sh_next = pub_addr_data;
						else
							out_sh_next = mmdia_pkg::UNMAPPED_DATA;
						rec_next = '{wr: 1'b0, reg_addr: hdr[4:0], data: mmdia_pkg::UNMAPPED_DATA};
						tog_next = !tog_reg;
					end
				end
			end
			mmdia_pkg::LS_TA: begin
				cnt_next = cnt_reg + 5'h01;
				if (cnt_reg != mmdia_pkg::TA_LAST) begin
					oe_next  = rd_reg;
					out_next = 1'b0;
				end else begin
					state_next  = mmdia_pkg::LS_DATA;
					cnt_next    = '0;
					out_next    = out_sh_reg[15];
					out_sh_next = {out_sh_reg[14:0], 1'b0};
				end
			end
			mmdia_pkg::LS_DATA: begin
				in_sh_next  = {in_sh_reg[14:0], mdio_in};
				cnt_next    = cnt_reg + 5'h01;
				out_next    = out_sh_reg[15];
				out_sh_next = {out_sh_reg[14:0], 1'b0};
				if (cnt_reg == mmdia_pkg::DATA_LAST) begin
					state_next = mmdia_pkg::LS_IDLE;
					oe_next    = 1'b0;
					out_next   = 1'b0;
					if (wr_reg && idle_ok) begin
						rec_next = '{wr: 1'b1, reg_addr: reg_addr_reg,
							data: {in_sh_reg[14:0], mdio_in}};
						tog_next = !tog_reg;
					end
				end
			end
			default: state_next = mmdia_pkg::LS_IDLE;
		endcase
	end

	always_ff @(posedge mdc) begin
		if (!rst_s2) begin
			state_reg    <= mmdia_pkg::LS_IDLE;
			rec_reg      <= mmdia_pkg::REQ_RESET;
			cnt_reg      <= '0;
			reg_addr_reg <= '0;
			in_sh_reg    <= '0;
			out_sh_reg   <= '0;
			rd_reg       <= 1'b0;
			wr_reg       <= 1'b0;
			tog_reg      <= 1'b0;
			out_reg      <= 1'b0;
			oe_reg       <= 1'b0;
		end else begin
			state_reg    <= state_next;
			rec_reg      <= rec_next;
			cnt_reg      <= cnt_next;
			reg_addr_reg <= reg_addr_next;
			in_sh_reg    <= in_sh_next;
			out_sh_reg   <= out_sh_next;
			rd_reg       <= rd_next;
			wr_reg       <= wr_next;
			tog_reg      <= tog_next;
			out_reg      <= out_next;
			oe_reg       <= oe_next;
		end
	end

	assign mdio_out = out_reg;
	assign mdio_oe  = oe_reg;
	assign req_tog  = tog_reg;
	assign req_rec  = rec_reg;

	property p_oe_only_read;
		@(posedge mdc) disable iff (!rst_s2)
		$rose(oe_reg) |-> rd_reg && (state_reg == mmdia_pkg::LS_TA);
	endproperty
	a_oe_only_read: assert property (p_oe_only_read) else $error("pin driven outside a read"); // RULE7
endmodule // mmdia_link

/* File: bench/mmdia_station.sv */
// station manager model: drives the management clock through frames and the idle bits around them,
// line idles high through the pull-up whenever nobody drives it
module mmdia_station (
	output logic      mdc,      // management clock, also ticked during idle bits between frames
	output logic      host_drv, // value the station puts on the data line
	output logic      host_oe,  // high while the station drives the line
	input  wire logic line      // resolved data line level
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		mdc      = 1'b0;
		host_drv = 1'b1;
		host_oe  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// uneven phases keep rising edges away from the core clock's edges
	task automatic tick();
		#37;
		mdc = 1'b1;
		#43;
		mdc = 1'b0;
	endtask

	task automatic idle(input int n);
		host_oe = 1'b0;
		repeat (n) tick();
	endtask

	// bits change only while the clock is low, ahead of the sampling rise
	task automatic send(input logic [31:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			host_oe  = 1'b1;
			host_drv = bits[i];
			tick();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic write(input logic [4:0] ra, input logic [15:0] d);
		idle(2);
		send({2'b01, mmdia_pkg::OP_WRITE, mmdia_pkg::PHY_ADDRESS, ra, 2'b10, d}, 32);
		idle(2);
	endtask

	// each bit is taken in mid-period, after the device's launching rise
	task automatic read(input logic [4:0] ra, output logic [15:0] d, output logic ta);
		idle(2);
		send({18'h00000, 2'b01, mmdia_pkg::OP_READ, mmdia_pkg::PHY_ADDRESS, ra}, 14);
		host_oe = 1'b0;
		tick();
		ta = line;
		for (int i = 15; i >= 0; i--) begin
			tick();
			d[i] = line;
		end
		tick();
		idle(1);
	endtask
endmodule // mmdia_station

/* File: bench/mmdia_mmd_access_tb.sv */
module mmdia_mmd_access_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk;
	logic resetn;
	logic mdc;
	logic line;
	logic mdio_out;
	logic mdio_oe;
	logic clk_out_oe;
	logic host_drv;
	logic host_oe;
	int   fails;
	int   checks_done;

	// pull-up wins when neither side drives
	assign line = mdio_oe ? mdio_out : (host_oe ? host_drv : 1'b1);

	always #5 ref_clk = ~ref_clk;

	mmdia_mmd_access dut (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.mdc        (mdc),
		.mdio_in    (line),
		.mdio_out   (mdio_out),
		.mdio_oe    (mdio_oe),
		.clk_out_oe (clk_out_oe)
	);

	mmdia_station sta (
		.mdc      (mdc),
		.host_drv (host_drv),
		.host_oe  (host_oe),
		.line     (line)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp1(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp, input string name);
		logic [15:0] d;
		logic        ta;
		sta.read(ra, d, ta);
		cmp1("turnaround low bit", 1'b0, ta);
		cmp16(name, exp, d);
	endtask

	task automatic set_ptr(input logic [15:0] p);
		sta.write(5'h0D, 16'h001F);
		sta.write(5'h0E, p);
	endtask

	task automatic ptr_chk(input logic [15:0] exp);
		sta.write(5'h0D, 16'h001F);
		rd_chk(5'h0E, exp, "pointer");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cmp1("clock out enable", 1'b1, clk_out_oe);
		rd_chk(5'h0D, 16'h0000, "control after reset");
		rd_chk(5'h02, 16'h0000, "unmapped direct");
		set_ptr(16'h0170);
		ptr_chk(16'h0170);
		sta.write(5'h0D, 16'h401F);
		rd_chk(5'h0E, 16'h0C10, "clock config reset");
		$display("test reset done");
	endtask

	task automatic t_incwr();
		set_ptr(16'h0171);
		sta.write(5'h0D, 16'hC01F);
		sta.write(5'h0E, 16'h0011);
		sta.write(5'h0E, 16'h0022);
		ptr_chk(16'h0173);
		set_ptr(16'h0171);
		sta.write(5'h0D, 16'hC01F);
		rd_chk(5'h0E, 16'h0011, "write-only inc read 1");
		rd_chk(5'h0E, 16'h0011, "write-only inc read 2");
		ptr_chk(16'h0171);
		$display("test increment on writes done");
	endtask

	task automatic t_incrd();
		set_ptr(16'h0171);
		sta.write(5'h0D, 16'h801F);
		rd_chk(5'h0E, 16'h0011, "burst read 1");
		rd_chk(5'h0E, 16'h0022, "burst read 2");
		rd_chk(5'h0E, 16'h0000, "burst read 3");
		ptr_chk(16'h0174);
		sta.write(5'h0D, 16'h801F);
		sta.write(5'h0E, 16'h0033);
		ptr_chk(16'h0175);
		$display("test increment on reads done");
	endtask

	task automatic t_fixed();
		set_ptr(16'h0175);
		sta.write(5'h0D, 16'h401F);
		sta.write(5'h0E, 16'h00A5);
		sta.write(5'h0E, 16'h005A);
		rd_chk(5'h0E, 16'h005A, "fixed read 1");
		rd_chk(5'h0E, 16'h005A, "fixed read 2");
		ptr_chk(16'h0175);
		$display("test no increment done");
	endtask

	task automatic t_dev_addr();
		set_ptr(16'h0170);
		sta.write(5'h0D, 16'h001E);
		rd_chk(5'h0E, 16'h0000, "wrong device read");
		sta.write(5'h0E, 16'h0199);
		ptr_chk(16'h0170);
		$display("test device address done");
	endtask

	task automatic t_self();
		set_ptr(16'h000D);
		sta.write(5'h0D, 16'h801F);
		sta.write(5'h0E, 16'h1234);
		rd_chk(5'h0D, 16'h801F, "control kept");
		ptr_chk(16'h000D);
		$display("test indirect self access done");
	endtask

	task automatic t_wrap();
		set_ptr(16'hFFFF);
		sta.write(5'h0D, 16'hC01F);
		sta.write(5'h0E, 16'h5555);
		ptr_chk(16'h0000);
		$display("test pointer wrap done");
	endtask

	// write's trailing idle bits outlast the core's update delay
	task automatic t_clkout();
		set_ptr(16'h0170);
		sta.write(5'h0D, 16'h401F);
		sta.write(5'h0E, 16'h0C50);
		cmp1("clock out enable", 1'b0, clk_out_oe);
		rd_chk(5'h0E, 16'h0C50, "clock config");
		$display("test clock output stop done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge ref_clk);
		fails++;
		wrap_up();
	end

	// the link side resynchronises reset, so its clock runs while held
	initial begin
		ref_clk     = 1'b0;
		resetn      = 1'b0;
		fails       = 0;
		checks_done = 0;
		fork
			repeat (16) @(negedge ref_clk);
			sta.idle(3);
		join
		@(negedge ref_clk);
		resetn = 1'b1;
		sta.idle(4);
		t_reset();
		t_incwr();
		t_incrd();
		t_fixed();
		t_dev_addr();
		t_self();
		t_wrap();
		t_clkout();
		wrap_up();
	end
endmodule // mmdia_mmd_access_tb
